// ===== hdl/inertial_defines.svh
`ifndef INERTIAL_DEFINES_SVH
`define INERTIAL_DEFINES_SVH

// Register offsets (byte address of the low byte)
`define OFS_X_ROTATION_RATE 8'h04
`define OFS_Y_ROTATION_RATE 8'h06
`define OFS_Z_ROTATION_RATE 8'h08
`define OFS_X_LINEAR_ACCEL 8'h0a
`define OFS_Y_LINEAR_ACCEL 8'h0c
`define OFS_Z_LINEAR_ACCEL 8'h0e
`define OFS_INTERNAL_TEMPERATURE 8'h18
`define OFS_DIAGNOSTIC_FLAGS 8'h3c

// Link framing
`define WORD_BITS 16
`define BIT_CNT_W 4
`define BIT_CNT_LAST 4'hf
`define CMD_WRITE_BIT 15
`define CMD_ADDR_HI 14
`define CMD_ADDR_LO 8
`define BURST_COMMAND 16'h3e00
`define BURST_WORDS 4'h8
`define BURST_IDX_W 4
`define READ_ZERO 16'h0000
`define TEMP_PAD 4'h0

// Pin synchroniser
`define SYNC_PINS 3

// Sample timing: rate in tenths of samples per second, clock in Hz
`define CLK_HZ 64'd250000000
`define ODR_SPS_X10 64'd8192
`define TENTHS 64'd10
`define SAMPLE_CNT_W 20

`endif

// ===== hdl/inertial_pkg.sv
package inertial_pkg;

	// One complete, coherent set of sensor words
	typedef struct packed {
		logic [15:0] rate_x;
		logic [15:0] rate_y;
		logic [15:0] rate_z;
		logic [15:0] accel_x;
		logic [15:0] accel_y;
		logic [15:0] accel_z;
		logic [11:0] temperature;
	} sensor_sample_type;

	// Host link input pins
	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic mosi;
	} link_pins_type;

	typedef enum logic [0:0] {
		mode_single = 1'b0,
		mode_burst = 1'b1
	} frame_mode_type;

endpackage

// ===== hdl/pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
`include "inertial_defines.svh"

module pin_sync (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	input wire logic clk_en,
	// Pins
	input wire inertial_pkg::link_pins_type pins_async,
	output inertial_pkg::link_pins_type pins_sync
);

	logic [`SYNC_PINS-1:0] stage1_reg;
	logic [`SYNC_PINS-1:0] stage2_reg;
	logic [`SYNC_PINS-1:0] stage1_next;
	logic [`SYNC_PINS-1:0] stage2_next;
	logic [`SYNC_PINS-1:0] raw;

	assign raw = pins_async;

	genvar i;
	generate
		for (i = 0; i < `SYNC_PINS; i++) begin : g_bit
			always_comb begin
				stage1_next[i] = clk_en ? raw[i] : stage1_reg[i];
				stage2_next[i] = clk_en ? stage1_reg[i] : stage2_reg[i];
			end
			// Reset loads every stage high, the idle level of cs_n and sclk
			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					stage1_reg[i] <= 1'b1;
					stage2_reg[i] <= 1'b1;
				end else begin
					stage1_reg[i] <= stage1_next[i];
					stage2_reg[i] <= stage2_next[i];
				end
			end
		end
	endgenerate

	assign pins_sync = stage2_reg;

endmodule // pin_sync

`default_nettype wire

// ===== hdl/inertial_output_data_registers.sv
// Overview of operation
// - Each sensor owns its own readable register
// - X rate: 16-bit signed at 0x04
// - Y rate: 16-bit signed at 0x06
// - Z rate: 16-bit signed at 0x08
// - Rates pass core scaling unchanged, zero is 0
// - X accel: 16-bit signed at 0x0a
// - Y accel: 16-bit signed at 0x0c
// - Z accel: 16-bit signed at 0x0e
// - Temperature 12-bit signed in low bits, 0x18
// - Self-timed refresh at 819.2 samples per second
// - Address word, contents returned next word
// - Command 0x3e00 streams eight words in order
`timescale 1ns/100ps
`default_nettype none
`include "inertial_defines.svh"

module inertial_output_data_registers #(
	parameter int sample_cycles = int'((`CLK_HZ * `TENTHS) / `ODR_SPS_X10)
) (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic resetn,
	input wire logic clk_en,
	// Sensor core side
	input wire inertial_pkg::sensor_sample_type core_sample,
	input wire logic [15:0] diagnostic_flags,
	output logic sample_tick,
	// Host link pins
	input wire inertial_pkg::link_pins_type link_pins,
	output logic miso_out,
	output logic miso_oe
);

	// ------------------------------------------------------------
	// Pin synchronisation
	// ------------------------------------------------------------
	inertial_pkg::link_pins_type pins;

	pin_sync u_pin_sync (
		.clk(clk),
		.resetn(resetn),
		.clk_en(clk_en),
		.pins_async(link_pins),
		.pins_sync(pins)
	);

	// ------------------------------------------------------------
	// Sample timer and snapshot
	// ------------------------------------------------------------
	localparam logic [`SAMPLE_CNT_W-1:0] sample_last = `SAMPLE_CNT_W'(sample_cycles - 1);

	logic [`SAMPLE_CNT_W-1:0] sample_cnt_reg;
	logic [`SAMPLE_CNT_W-1:0] sample_cnt_next;
	logic sample_tick_reg;
	logic sample_tick_next;
	inertial_pkg::sensor_sample_type snap_reg;
	inertial_pkg::sensor_sample_type snap_next;

	always_comb begin
		sample_cnt_next = sample_cnt_reg;
		sample_tick_next = 1'b0;
		snap_next = snap_reg;
		if (sample_cnt_reg == sample_last) begin
			sample_cnt_next = '0;
			sample_tick_next = 1'b1;
			snap_next = core_sample;
		end else begin
			sample_cnt_next = sample_cnt_reg + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sample_cnt_reg <= '0;
			sample_tick_reg <= 1'b0;
			snap_reg <= '0;
		end else if (clk_en) begin
			sample_cnt_reg <= sample_cnt_next;
			sample_tick_reg <= sample_tick_next;
			snap_reg <= snap_next;
		end
	end

	assign sample_tick = sample_tick_reg;

	// ------------------------------------------------------------
	// Register read map
	// ------------------------------------------------------------
	logic [15:0] burst_words [0:7];
	logic [15:0] temp_word;
	logic [15:0] rx_word;
	logic [7:0] rd_offset;
	logic [15:0] rd_data;

	assign temp_word = {`TEMP_PAD, snap_reg.temperature};

	// Burst order: status, three rates, three accelerations, temperature
	assign burst_words[0] = diagnostic_flags;
	assign burst_words[1] = snap_reg.rate_x;
	assign burst_words[2] = snap_reg.rate_y;
	assign burst_words[3] = snap_reg.rate_z;
	assign burst_words[4] = snap_reg.accel_x;
	assign burst_words[5] = snap_reg.accel_y;
	assign burst_words[6] = snap_reg.accel_z;
	assign burst_words[7] = temp_word;

	always_comb begin
		rd_offset = {1'b0, rx_word[`CMD_ADDR_HI:`CMD_ADDR_LO]};
		unique case (rd_offset)
			`OFS_X_ROTATION_RATE: rd_data = snap_reg.rate_x;
			`OFS_Y_ROTATION_RATE: rd_data = snap_reg.rate_y;
			`OFS_Z_ROTATION_RATE: rd_data = snap_reg.rate_z;
			`OFS_X_LINEAR_ACCEL: rd_data = snap_reg.accel_x;
			`OFS_Y_LINEAR_ACCEL: rd_data = snap_reg.accel_y;
			`OFS_Z_LINEAR_ACCEL: rd_data = snap_reg.accel_z;
			`OFS_INTERNAL_TEMPERATURE: rd_data = temp_word;
			`OFS_DIAGNOSTIC_FLAGS: rd_data = diagnostic_flags;
			default: rd_data = `READ_ZERO;
		endcase
	end

	// ------------------------------------------------------------
	// Serial link, clock idles high, sample on rise, change on fall
	// ------------------------------------------------------------
	logic sclk_prev_reg;
	logic sclk_prev_next;
	logic cs_prev_reg;
	logic cs_prev_next;
	logic [`BIT_CNT_W-1:0] bit_cnt_reg;
	logic [`BIT_CNT_W-1:0] bit_cnt_next;
	logic [15:0] rx_reg;
	logic [15:0] rx_next;
	logic [15:0] tx_reg;
	logic [15:0] tx_next;
	inertial_pkg::frame_mode_type mode_reg;
	inertial_pkg::frame_mode_type mode_next;
	logic [`BURST_IDX_W-1:0] burst_idx_reg;
	logic [`BURST_IDX_W-1:0] burst_idx_next;
	logic miso_reg;
	logic miso_next;
	logic oe_reg;
	logic oe_next;
	logic sclk_rise;
	logic sclk_fall;
	logic selected;
	logic cs_fall;

	assign selected = !pins.cs_n;
	assign cs_fall = cs_prev_reg && !pins.cs_n;
	assign sclk_rise = selected && !sclk_prev_reg && pins.sclk;
	assign sclk_fall = selected && sclk_prev_reg && !pins.sclk;
	assign rx_word = {rx_reg[14:0], pins.mosi};

	always_comb begin
		sclk_prev_next = pins.sclk;
		cs_prev_next = pins.cs_n;
		bit_cnt_next = bit_cnt_reg;
		rx_next = rx_reg;
		tx_next = tx_reg;
		mode_next = mode_reg;
		burst_idx_next = burst_idx_reg;
		miso_next = miso_reg;
		oe_next = selected;
		if (!selected) begin
			// Deselect aborts a partial word and ends any burst
			bit_cnt_next = '0;
			mode_next = inertial_pkg::mode_single;
		end else begin
			if (cs_fall) begin
				miso_next = tx_reg[`WORD_BITS-1];
			end
			// A zero count at a fall starts a new word, so its top bit goes out
			if (sclk_fall) begin
				miso_next = tx_reg[`BIT_CNT_LAST - bit_cnt_reg];
			end
			if (sclk_rise) begin
				rx_next = rx_word;
				bit_cnt_next = bit_cnt_reg + 1'b1;
				if (bit_cnt_reg == `BIT_CNT_LAST) begin
					// Whole word loaded at once at the word boundary
					if (mode_reg == inertial_pkg::mode_burst) begin
						if (burst_idx_reg == `BURST_WORDS) begin
							mode_next = inertial_pkg::mode_single;
							tx_next = `READ_ZERO;
						end else begin
							tx_next = burst_words[burst_idx_reg[2:0]];
							burst_idx_next = burst_idx_reg + 1'b1;
						end
					end else if (rx_word == `BURST_COMMAND) begin
						mode_next = inertial_pkg::mode_burst;
						tx_next = burst_words[0];
						burst_idx_next = `BURST_IDX_W'(1);
					end else if (rx_word[`CMD_WRITE_BIT]) begin
						tx_next = `READ_ZERO;
					end else begin
						tx_next = rd_data;
					end
				end
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sclk_prev_reg <= 1'b1;
			cs_prev_reg <= 1'b1;
			bit_cnt_reg <= '0;
			rx_reg <= '0;
			tx_reg <= '0;
			mode_reg <= inertial_pkg::mode_single;
			burst_idx_reg <= '0;
			miso_reg <= 1'b0;
			oe_reg <= 1'b0;
		end else if (clk_en) begin
			sclk_prev_reg <= sclk_prev_next;
			cs_prev_reg <= cs_prev_next;
			bit_cnt_reg <= bit_cnt_next;
			rx_reg <= rx_next;
			tx_reg <= tx_next;
			mode_reg <= mode_next;
			burst_idx_reg <= burst_idx_next;
			miso_reg <= miso_next;
			oe_reg <= oe_next;
		end
	end

	assign miso_out = miso_reg;
	assign miso_oe = oe_reg;

endmodule // inertial_output_data_registers

`default_nettype wire

// ===== dv/inertial_output_data_registers_chk.sv
`timescale 1ns/100ps
`default_nettype none

module inertial_output_data_registers_chk #(
	parameter int sample_cycles = 8000
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	input wire logic clk_en,
	// Watched ports
	input wire logic sample_tick,
	input wire inertial_pkg::link_pins_type link_pins,
	input wire logic miso_out,
	input wire logic miso_oe
);
	logic [19:0] gap_reg, gap_next;
	logic seen_reg, seen_next;

	// Enabled cycles since the previous refresh pulse
	always_comb begin
		gap_next = gap_reg;
		if (clk_en) begin
			gap_next = sample_tick ? 20'h0 : gap_reg + 20'h1;
		end
		seen_next = seen_reg | sample_tick;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			gap_reg <= 20'h0;
			seen_reg <= 1'h0;
		end else begin
			gap_reg <= gap_next;
			seen_reg <= seen_next;
		end
	end

	// ----------
	// Assertions
	// ----------
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	a_tick_one_cycle: assert property (sample_tick && clk_en |=> !sample_tick)
		else $error("tick long");
	a_tick_period: assert property (sample_tick && clk_en && seen_reg |->
		gap_reg == 20'(sample_cycles - 1))
		else $error("tick period");
	a_oe_on: assert property (!link_pins.cs_n [*6] |-> miso_oe)
		else $error("oe missing");
	a_oe_off: assert property (link_pins.cs_n [*6] |-> !miso_oe)
		else $error("oe stuck");
	a_oe_rise_cause: assert property ($rose(miso_oe) |-> !$past(link_pins.cs_n, 2))
		else $error("oe rose early");
	a_oe_fall_cause: assert property ($fell(miso_oe) |-> $past(link_pins.cs_n, 2))
		else $error("oe fell early");
	a_bit_held: assert property ((!link_pins.cs_n && link_pins.sclk) [*8] |-> $stable(miso_out))
		else $error("miso moved");
	a_reset_quiet: assert property ($rose(resetn) |-> !sample_tick && !miso_oe && !miso_out)
		else $error("not quiet");

	c_tick: cover property (sample_tick);
	c_oe_on: cover property ($rose(miso_oe));
	c_oe_off: cover property ($fell(miso_oe));
endmodule // inertial_output_data_registers_chk

bind inertial_output_data_registers inertial_output_data_registers_chk #(
	.sample_cycles(sample_cycles)
) chk (.clk(clk), .resetn(resetn), .clk_en(clk_en), .sample_tick(sample_tick),
	.link_pins(link_pins),
	.miso_out(miso_out), .miso_oe(miso_oe));
`default_nettype wire

// ===== dv/host_link_model.sv
`timescale 1ns/100ps
`default_nettype none

module host_link_model (
	// Bench clock
	input wire logic clk,
	// Link pins
	output var inertial_pkg::link_pins_type pins,
	input wire logic miso
);
	// Half of the 160 ns link clock, in bench clock cycles
	localparam int half_period = 20;

	// Clock idles high; data changes on the fall, is sampled on the rise
	initial pins = 3'h6;

	task sel(input logic s);
		repeat (half_period) @(posedge clk);
		pins.cs_n <= s;
		repeat (half_period) @(posedge clk);
	endtask

	task word(input logic [15:0] tx, output logic [15:0] rx);
		for (int i = 15; i >= 0; i--) begin
			pins.sclk <= 1'h0;
			pins.mosi <= tx[i];
			repeat (half_period) @(posedge clk);
			pins.sclk <= 1'h1;
			rx[i] = miso;
			repeat (half_period) @(posedge clk);
		end
	endtask
endmodule // host_link_model
`default_nettype wire

// ===== dv/inertial_output_data_registers_test.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, w) begin num_checks++; if ((g) !== (w)) begin fails++; \
	$display("Error %0t: got %h want %h", $time, (g), (w)); end end

module inertial_output_data_registers_test;
	logic clk, resetn, clk_en, sample_tick, miso_out, miso_oe;
	inertial_pkg::sensor_sample_type core_sample, a;
	inertial_pkg::link_pins_type link_pins;
	logic [15:0] diagnostic_flags;
	wire logic miso;
	int fails, num_checks, cyc;

	assign miso = miso_oe ? miso_out : 1'hz;

	inertial_output_data_registers #(.sample_cycles(8000)) dut (.clk(clk), .resetn(resetn),
		.clk_en(clk_en), .core_sample(core_sample), .diagnostic_flags(diagnostic_flags),
		.sample_tick(sample_tick), .link_pins(link_pins), .miso_out(miso_out), .miso_oe(miso_oe));
	host_link_model host (.clk(clk), .pins(link_pins), .miso(miso));

	// ---------
	// Scenarios
	// ---------
	task complete_run;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task wait_tick;
		do @(negedge clk); while (sample_tick !== 1'h1);
	endtask

	// Pipelined single reads; core input changes right after the snapshot
	task t_single;
		logic [15:0] tx [10];
		logic [15:0] ex [11];
		logic [15:0] rx;
		tx = '{16'h0400, 16'h0600, 16'h0800, 16'h0a00, 16'h0c00, 16'h0e00, 16'h1800, 16'h3c00,
			16'h1000, 16'h8400};
		ex = '{16'h0, a.rate_x, a.rate_y, a.rate_z, a.accel_x, a.accel_y, a.accel_z,
			{4'h0, a.temperature}, diagnostic_flags, 16'h0, 16'h0};
		wait_tick;
		@(posedge clk) core_sample <= ~a;
		host.sel(1'h0);
		`CHK(miso_oe, 1'h1)
		for (int i = 0; i < 11; i++) begin
			host.word(i < 10 ? tx[i] : 16'h0, rx);
			if (i > 0) `CHK(rx, ex[i])
		end
		host.sel(1'h1);
		`CHK(miso_oe, 1'h0)
	endtask

	// Enable held low for 100 cycles pushes the next refresh back by as much
	task t_freeze;
		int n;
		n = 0;
		wait_tick;
		@(posedge clk) clk_en <= 1'h0;
		repeat (100) @(posedge clk);
		clk_en <= 1'h1;
		do begin
			@(negedge clk);
			n++;
		end while (sample_tick !== 1'h1 && n < 9000);
		`CHK(n, 8000)
	endtask

	// Burst of eight words, then the stream falls back to zero
	task t_burst;
		logic [15:0] rx;
		logic [15:0] ex [9];
		inertial_pkg::sensor_sample_type b;
		b = ~a;
		ex = '{diagnostic_flags, b.rate_x, b.rate_y, b.rate_z, b.accel_x, b.accel_y, b.accel_z,
			{4'h0, b.temperature}, 16'h0};
		wait_tick;
		host.sel(1'h0);
		host.word(16'h3e00, rx);
		for (int i = 0; i < 9; i++) begin
			host.word(16'h0, rx);
			`CHK(rx, ex[i])
		end
		host.sel(1'h1);
	endtask

	initial begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 50000) begin
			fails++;
			complete_run;
		end
	end

	initial begin
		a = '{16'h61a8, 16'h9e58, 16'h0000, 16'h0fa0, 16'hf060, 16'h0001, 12'hc3e};
		core_sample = a;
		diagnostic_flags = 16'h0024;
		clk_en = 1'h1;
		resetn = 1'h0;
		repeat (4) @(posedge clk);
		resetn <= 1'h1;
		t_single;
		t_burst;
		t_freeze;
		complete_run;
	end
endmodule // inertial_output_data_registers_test
`default_nettype wire
